/* File: design/ctpg_clk_div.sv */
// programmable tick divider: one output tick per (ratio + 1) source ticks
`timescale 1ns/100ps
`default_nettype none

module ctpg_clk_div
  import ctpg_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  // divider link
  ctpg_div_if.div   dIf
);

  logic [DIV_W-1:0] cnt_q;
  logic             outTick_q;
  logic             clkLvl_q;
  logic             wrap;

  // a shrunk ratio mid-count wraps at once instead of running to 255
  assign wrap = (cnt_q >= dIf.ratio);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_q <= '0;
    end else if (dIf.srcTick) begin
      cnt_q <= wrap ? '0 : cnt_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      outTick_q <= 1'b0;
    end else begin
      outTick_q <= dIf.srcTick & wrap;
    end
  end

  // level view of the divided clock, high while the count is at most half the ratio
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clkLvl_q <= 1'b0;
    end else begin
      clkLvl_q <= (cnt_q <= (dIf.ratio >> 1));
    end
  end

  assign dIf.outTick = outTick_q;
  assign dIf.clkLvl  = clkLvl_q;

endmodule : ctpg_clk_div

`default_nettype wire

/* File: design/ctpg_clock_tree.sv */
// clock tree and pulse width generator top with axi4-lite register slave
//
// Behaviour
// RULE1: primary and secondary clock inputs feed the tree; the secondary may be absent.
// RULE2: pixel clock source selects primary, secondary, bus clock or memory clock.
// RULE3: pixel clock is its selected source divided by a programmable ratio.
// RULE4: bus clock always comes from the primary input divided by a ratio.
// RULE5: memory clock always comes from the bus clock divided by its ratio.
// RULE6: software keeps the memory divider at one unless memory clock would be too fast.
// RULE7: clearing the pulse width clock enable stops that circuitry.
// RULE8: force-high drives the pulse width output high regardless of the modulator.
// RULE9: without force-high, output is low when modulation is off, modulated when on.
// RULE10: pulse width clock source selects primary, secondary, memory or pixel clock.
// RULE11: pulse width source divided by a ratio, then by 256 for the period.
// RULE12: duty value sets high periods out of every 256.
// RULE13: dividers are register fields; source changes are glitch free.
`timescale 1ns/100ps
`default_nettype none

module ctpg_clock_tree
  import ctpg_pkg::*;
(
  // clock and reset
  input  wire logic                                    sys_clk,
  input  wire logic                                    srst,
  // external clock pins
  input  wire logic                                    primaryClockInput,
  input  wire logic                                    secondaryClockInput,
  // axi4-lite write address
  input  wire logic                                    s_axi_awvalid,
  output var  logic                                    s_axi_awready,
  input  wire logic [ctpg_pkg::AXI_ADDR_W-1:0]         s_axi_awaddr,
  // axi4-lite write data
  input  wire logic                                    s_axi_wvalid,
  output var  logic                                    s_axi_wready,
  input  wire logic [ctpg_pkg::AXI_DATA_W-1:0]         s_axi_wdata,
  input  wire logic [ctpg_pkg::AXI_DATA_W/8-1:0]       s_axi_wstrb,
  // axi4-lite write response
  output var  logic                                    s_axi_bvalid,
  input  wire logic                                    s_axi_bready,
  output var  logic [1:0]                              s_axi_bresp,
  // axi4-lite read address
  input  wire logic                                    s_axi_arvalid,
  output var  logic                                    s_axi_arready,
  input  wire logic [ctpg_pkg::AXI_ADDR_W-1:0]         s_axi_araddr,
  // axi4-lite read data
  output var  logic                                    s_axi_rvalid,
  input  wire logic                                    s_axi_rready,
  output var  logic [ctpg_pkg::AXI_DATA_W-1:0]         s_axi_rdata,
  output var  logic [1:0]                              s_axi_rresp,
  // derived clock levels
  output var  logic                                    busClock,
  output var  logic                                    memoryClock,
  output var  logic                                    pixelClock,
  // panel side
  output var  logic                                    pulseWidthOutput
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic pickTick(input logic [1:0] sel, input logic t0, input logic t1,
                                    input logic t2, input logic t3);
    case (sel)
      2'b00:   pickTick = t0;
      2'b01:   pickTick = t1;
      2'b10:   pickTick = t2;
      2'b11:   pickTick = t3;
      default: pickTick = 1'b0;
    endcase
  endfunction : pickTick

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] neu,
                                             input logic [3:0] strb);
    mergeBytes = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        mergeBytes[b*8 +: 8] = neu[b*8 +: 8];
      end
    end
  endfunction : mergeBytes

  function automatic logic isMapped(input logic [AXI_ADDR_W-1:0] a);
    isMapped = (a == CLK_CFG_OFS) || (a == PWM_CTRL_OFS) ||
               (a == PWM_DUTY_OFS) || (a == CLK_STATUS_OFS);
  endfunction : isMapped

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge ticks

  // pins are asynchronous to sys_clk; each sees two flops before the edge detector
  logic [1:0] pinMeta_q;
  logic [1:0] pinSync_q;
  logic [1:0] pinPrev_q;
  logic [1:0] pinTick_q;
  logic [1:0] pinRaw;

  assign pinRaw = {secondaryClockInput, primaryClockInput};

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
    end else begin
      pinMeta_q <= pinRaw;
      pinSync_q <= pinMeta_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pinPrev_q <= '0;
      pinTick_q <= '0;
    end else begin
      pinPrev_q <= pinSync_q;
      pinTick_q <= pinSync_q & ~pinPrev_q; // RULE1
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // secondary input activity

  // an absent secondary clock simply never ticks; status shows whether it runs
  logic [11:0] secIdle_q;
  logic        secActive_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      secIdle_q <= SRC_IDLE_CYCLES;
    end else if (pinTick_q[1]) begin
      secIdle_q <= '0;
    end else if (secIdle_q != SRC_IDLE_CYCLES) begin
      secIdle_q <= secIdle_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      secActive_q <= 1'b0;
    end else begin
      secActive_q <= (secIdle_q != SRC_IDLE_CYCLES); // RULE1
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic [31:0] clkCfg_q;
  logic [31:0] pwmCtrl_q;
  logic [31:0] pwmDuty_q;
  logic [31:0] status;

  ////////////////////////////////////////////////////////////////////////////
  // dividers: 0 bus, 1 memory, 2 pixel, 3 pulse width

  localparam int NDIV = 4;
  ctpg_div_if divIf [NDIV] ();

  logic [NDIV-1:0]  divSrc;
  logic [NDIV-1:0]  divTick;
  logic [NDIV-1:0]  divLvl;
  logic [DIV_W-1:0] divRatio [NDIV];

  assign divRatio[0] = clkCfg_q[BUS_DIV_LSB +: DIV_W];
  assign divRatio[1] = clkCfg_q[MEM_DIV_LSB +: DIV_W];
  assign divRatio[2] = clkCfg_q[PIX_DIV_LSB +: DIV_W];
  assign divRatio[3] = pwmCtrl_q[PWM_DIV_LSB +: DIV_W];

  for (genvar i = 0; i < NDIV; i++) begin : gDiv
    assign divIf[i].srcTick = divSrc[i];
    assign divIf[i].ratio   = divRatio[i]; // RULE13
    assign divTick[i]       = divIf[i].outTick;
    assign divLvl[i]        = divIf[i].clkLvl;
    ctpg_clk_div uDiv (
      .sys_clk (sys_clk),
      .srst    (srst),
      .dIf     (divIf[i])
    );
  end : gDiv

  ////////////////////////////////////////////////////////////////////////////
  // glitch-free source selection for pixel (0) and pulse width (1) clocks

  // new source waits for a period boundary or a quiet old source: no runt period
  logic [1:0]  selReq   [2];
  logic [1:0]  selAct_q [2];
  logic [11:0] selIdle_q [2];
  logic [1:0]  muxTick;
  logic [1:0]  muxBound;

  assign selReq[0]   = clkCfg_q[PIX_SEL_LSB +: 2];
  assign selReq[1]   = pwmCtrl_q[PWM_SEL_LSB +: 2];
  assign muxTick[0]  = pickTick(selAct_q[0], pinTick_q[0], pinTick_q[1],
                                divTick[0], divTick[1]); // RULE2
  assign muxTick[1]  = pickTick(selAct_q[1], pinTick_q[0], pinTick_q[1],
                                divTick[1], divTick[2]); // RULE10
  assign muxBound[0] = divTick[2];
  assign muxBound[1] = divTick[3];

  for (genvar m = 0; m < 2; m++) begin : gSel
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        selIdle_q[m] <= '0;
      end else if (muxTick[m]) begin
        selIdle_q[m] <= '0;
      end else if (selIdle_q[m] != SRC_IDLE_CYCLES) begin
        selIdle_q[m] <= selIdle_q[m] + 1'b1;
      end
    end

    always_ff @(posedge sys_clk) begin
      if (srst) begin
        selAct_q[m] <= 2'b00;
      end else if (muxBound[m] || (selIdle_q[m] == SRC_IDLE_CYCLES)) begin
        selAct_q[m] <= selReq[m]; // RULE13
      end
    end
  end : gSel

  assign divSrc[0] = pinTick_q[0];                           // RULE4
  assign divSrc[1] = divTick[0];                             // RULE5
  assign divSrc[2] = muxTick[0];                             // RULE3
  assign divSrc[3] = muxTick[1] & pwmCtrl_q[PWM_CLKEN_BIT];  // RULE7 RULE11

  ////////////////////////////////////////////////////////////////////////////
  // modulator

  ctpg_pwm_if pwmIf ();

  assign pwmIf.tick      = divTick[3];
  assign pwmIf.clkEn     = pwmCtrl_q[PWM_CLKEN_BIT]; // RULE7
  assign pwmIf.modEn     = pwmCtrl_q[PWM_MODEN_BIT]; // RULE9
  assign pwmIf.forceHigh = pwmCtrl_q[PWM_FORCE_BIT]; // RULE8
  assign pwmIf.duty      = pwmDuty_q[DUTY_W-1:0];    // RULE12

  ctpg_pwm uPwm (
    .sys_clk (sys_clk),
    .srst    (srst),
    .pIf     (pwmIf)
  );

  assign pulseWidthOutput = pwmIf.pulse_width_output;

  ////////////////////////////////////////////////////////////////////////////
  // clock level outputs

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      {pixelClock, memoryClock, busClock} <= 3'h0;
    end else begin
      {pixelClock, memoryClock, busClock} <= divLvl[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel

  logic                  awHeld_q;
  logic                  wHeld_q;
  logic [AXI_ADDR_W-1:0] awAddr_q;
  logic [31:0]           wData_q;
  logic [3:0]            wStrb_q;
  logic                  doWrite;

  // address and data are taken in either order; the write lands once both are in
  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      awHeld_q      <= 1'b0;
      awAddr_q      <= '0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_q      <= 1'b1;
      awAddr_q      <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      awHeld_q      <= awHeld_q && !doWrite;
      s_axi_awready <= s_axi_awready || (!awHeld_q && !s_axi_bvalid);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wHeld_q      <= 1'b0;
      wData_q      <= '0;
      wStrb_q      <= '0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_q      <= 1'b1;
      wData_q      <= s_axi_wdata;
      wStrb_q      <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else begin
      wHeld_q      <= wHeld_q && !doWrite;
      s_axi_wready <= s_axi_wready || (!wHeld_q && !s_axi_bvalid);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (isMapped(awAddr_q) && awAddr_q != CLK_STATUS_OFS) ? RESP_OKAY
                                                                        : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // software is trusted to keep the memory divider at one unless needed
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clkCfg_q  <= CLK_CFG_RST;
      pwmCtrl_q <= PWM_CTRL_RST;
      pwmDuty_q <= PWM_DUTY_RST;
    end else if (doWrite) begin
      case (awAddr_q)
        CLK_CFG_OFS:  clkCfg_q  <= mergeBytes(clkCfg_q, wData_q, wStrb_q) & 32'h03FF_FFFF;
        PWM_CTRL_OFS: pwmCtrl_q <= mergeBytes(pwmCtrl_q, wData_q, wStrb_q) & 32'h0007_03FF;
        PWM_DUTY_OFS: pwmDuty_q <= mergeBytes(pwmDuty_q, wData_q, wStrb_q) & 32'h0000_00FF;
        default:      clkCfg_q  <= clkCfg_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status and axi4-lite read channel

  always_comb begin
    status                                = '0;
    status[STS_SEC_BIT]                   = secActive_q;
    status[STS_OUT_BIT]                   = pwmIf.pulse_width_output;
    status[STS_PIXSEL_LSB +: 2]           = selAct_q[0];
    status[STS_PWMSEL_LSB +: 2]           = selAct_q[1];
    status[STS_CLKLVL_LSB +: NDIV]        = divLvl;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        CLK_CFG_OFS:    s_axi_rdata <= clkCfg_q;
        PWM_CTRL_OFS:   s_axi_rdata <= pwmCtrl_q;
        PWM_DUTY_OFS:   s_axi_rdata <= pwmDuty_q;
        CLK_STATUS_OFS: s_axi_rdata <= status;
        default:        s_axi_rdata <= '0;
      endcase
    end else if (s_axi_rvalid) begin
      s_axi_rvalid <= !s_axi_rready;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule : ctpg_clock_tree

`default_nettype wire

/* File: design/ctpg_if.sv */
// interfaces between the clock tree top and its divider and modulator
`timescale 1ns/100ps
`default_nettype none

interface ctpg_div_if;
  logic                       srcTick;
  logic [ctpg_pkg::DIV_W-1:0] ratio;
  logic                       outTick;
  logic                       clkLvl;
  modport ctrl (output srcTick, output ratio, input outTick, input clkLvl);
  modport div  (input srcTick, input ratio, output outTick, output clkLvl);
endinterface : ctpg_div_if

interface ctpg_pwm_if;
  logic                        tick;
  logic                        clkEn;
  logic                        modEn;
  logic                        forceHigh;
  logic [ctpg_pkg::DUTY_W-1:0] duty;
  logic                        pulse_width_output;
  logic                        periodTick;
  modport ctrl (output tick, output clkEn, output modEn, output forceHigh, output duty,
                input pulse_width_output, input periodTick);
  modport pwm  (input tick, input clkEn, input modEn, input forceHigh, input duty,
                output pulse_width_output, output periodTick);
endinterface : ctpg_pwm_if

`default_nettype wire

/* File: design/ctpg_pkg.sv */
// constants, field layouts and reset values for the clock tree and pwm generator
package ctpg_pkg;

  // bus geometry
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam int DIV_W      = 8;
  localparam int DUTY_W     = 8;

  // register byte offsets
  localparam logic [7:0] CLK_CFG_OFS    = 8'h00;
  localparam logic [7:0] PWM_CTRL_OFS   = 8'h04;
  localparam logic [7:0] PWM_DUTY_OFS   = 8'h08;
  localparam logic [7:0] CLK_STATUS_OFS = 8'h0C;

  // clock configuration fields
  localparam int BUS_DIV_LSB = 0;
  localparam int MEM_DIV_LSB = 8;
  localparam int PIX_DIV_LSB = 16;
  localparam int PIX_SEL_LSB = 24;

  // pwm control fields
  localparam int PWM_DIV_LSB   = 0;
  localparam int PWM_SEL_LSB   = 8;
  localparam int PWM_CLKEN_BIT = 16;
  localparam int PWM_FORCE_BIT = 17;
  localparam int PWM_MODEN_BIT = 18;

  // status fields
  localparam int STS_SEC_BIT     = 0;
  localparam int STS_OUT_BIT     = 1;
  localparam int STS_PIXSEL_LSB  = 2;
  localparam int STS_PWMSEL_LSB  = 4;
  localparam int STS_CLKLVL_LSB  = 6;

  // reset values: every divider field 0 means divide by one
  localparam logic [31:0] CLK_CFG_RST  = 32'h0000_0000;
  localparam logic [31:0] PWM_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PWM_DUTY_RST = 32'h0000_0000;

  // source idle limit in sys_clk cycles, for activity and select handover
  localparam logic [11:0] SRC_IDLE_CYCLES = 12'h400;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // pixel clock sources
  typedef enum logic [1:0] {
    PIX_SRC_PRIMARY   = 2'b00,
    PIX_SRC_SECONDARY = 2'b01,
    PIX_SRC_BUS       = 2'b10,
    PIX_SRC_MEMORY    = 2'b11
  } ctpg_pix_src_t;

  // pulse width clock sources
  typedef enum logic [1:0] {
    PWM_SRC_PRIMARY   = 2'b00,
    PWM_SRC_SECONDARY = 2'b01,
    PWM_SRC_MEMORY    = 2'b10,
    PWM_SRC_PIXEL     = 2'b11
  } ctpg_pwm_src_t;

endpackage : ctpg_pkg

/* File: design/ctpg_pwm.sv */
// pulse width modulator: duty counted over 256 pulse width clock periods
`timescale 1ns/100ps
`default_nettype none

module ctpg_pwm
  import ctpg_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  // modulator link
  ctpg_pwm_if.pwm   pIf
);

  logic [DUTY_W-1:0] phase_q;
  logic              out_q;
  logic              period_q;

  // fixed divide by 256 through the 8-bit phase wrap
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      phase_q <= '0;
    end else if (!pIf.clkEn) begin
      phase_q <= '0; // RULE7
    end else if (pIf.tick) begin
      phase_q <= phase_q + 1'b1; // RULE11
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      period_q <= 1'b0;
    end else begin
      period_q <= pIf.clkEn & pIf.tick & (phase_q == '1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      out_q <= 1'b0;
    end else if (pIf.forceHigh) begin
      out_q <= 1'b1; // RULE8
    end else if (!pIf.modEn || !pIf.clkEn) begin
      out_q <= 1'b0; // RULE9
    end else begin
      out_q <= (phase_q < pIf.duty); // RULE12
    end
  end

  assign pIf.pulse_width_output     = out_q;
  assign pIf.periodTick = period_q;

endmodule : ctpg_pwm

`default_nettype wire

/* File: tb/ctpg_clock_tree_chk.sv */
// assertions on the clock tree top ports
`timescale 1ns/100ps
`default_nettype none

module ctpg_clock_tree_chk
  import ctpg_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        srst,
  // write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  // read channels
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // derived clock
  input wire logic        busClock
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write accepted while busy");
  a_err_data: assert property (
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
    else $error("error read carries data");
  a_ar_return: assert property ($fell(s_axi_rvalid) |-> ##[0:2] s_axi_arready)
    else $error("read ready not restored");
  a_bus_level: assert property ($rose(busClock) |=> busClock [*2])
    else $error("bus clock high too short");
endmodule : ctpg_clock_tree_chk

`default_nettype wire

/* File: tb/ctpg_panel_model.sv */
// panel side model integrating the pulse width output
`timescale 1ns/100ps
`default_nettype none

module ctpg_panel_model (
  // clock and control
  input  wire logic        sys_clk,
  input  wire logic        clr,
  // panel input
  input  wire logic        pwmIn,
  // high time seen
  output var  logic [15:0] highCnt
);
  // a backlight integrates the level, so only high time matters
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      highCnt <= 16'h0000;
    end else begin
      highCnt <= highCnt + {15'h0000, pwmIn};
    end
  end
endmodule : ctpg_panel_model

`default_nettype wire

/* File: tb/tb_top.sv */
// top bench: bus traffic, clock periods and pulse width scenarios
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import ctpg_pkg::*;
  logic        sys_clk, srst, clr;
  logic        pri = 1'b0;
  logic        sec = 1'b0;
  logic        awValid, awReady, wValid, wReady, bValid, bReady;
  logic        arValid, arReady, rValid, rReady;
  logic [7:0]  awAddr, arAddr;
  logic [31:0] wData, rData;
  logic [1:0]  bResp, rResp;
  logic        busClock, memoryClock, pixelClock, pulse_width_output;
  logic [15:0] highCnt;
  int          err_total, total_checks;
  int          cyc = 0;

  ctpg_clock_tree uut (.sys_clk(sys_clk), .srst(srst), .primaryClockInput(pri),
    .secondaryClockInput(sec), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_awaddr(awAddr), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_bresp(bResp), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_araddr(arAddr), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .busClock(busClock),
    .memoryClock(memoryClock), .pixelClock(pixelClock), .pulseWidthOutput(pulse_width_output));

  ctpg_panel_model panel (.sys_clk(sys_clk), .clr(clr), .pwmIn(pulse_width_output), .highCnt(highCnt));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // pins derived from sys_clk so measured periods are exact
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) pri <= ~pri;
    if (cyc % 6 == 5) sec <= ~sec;
    if (cyc == 80000) begin
      err_total++;
      end_sim();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge sys_clk);
    awValid <= 1'b1;
    awAddr  <= a;
    wValid  <= 1'b1;
    wData   <= d;
    bReady  <= 1'b1;
    do begin
      @(negedge sys_clk);
      ta = awValid && awReady;
      tw = wValid && wReady;
      tb = bValid;
      r  = bResp;
      @(posedge sys_clk);
      if (ta) awValid <= 1'b0;
      if (tw) wValid <= 1'b0;
    end while (!tb);
    bReady <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge sys_clk);
    arValid <= 1'b1;
    arAddr  <= a;
    rReady  <= 1'b1;
    do begin
      @(negedge sys_clk);
      ta = arValid && arReady;
      tr = rValid;
      d  = rData;
      r  = rResp;
      @(posedge sys_clk);
      if (ta) arValid <= 1'b0;
    end while (!tr);
    rReady <= 1'b0;
  endtask : rd

  function automatic logic lvl(input int s);
    return (s == 0) ? busClock : (s == 1) ? memoryClock : pixelClock;
  endfunction : lvl

  // rise to rise, in sys_clk cycles
  task automatic per(input int s, output int n);
    n = 0;
    @(negedge sys_clk);
    while (lvl(s) !== 1'b0) @(negedge sys_clk);
    while (lvl(s) !== 1'b1) @(negedge sys_clk);
    while (lvl(s) !== 1'b0) begin
      @(negedge sys_clk);
      n++;
    end
    while (lvl(s) !== 1'b1) begin
      @(negedge sys_clk);
      n++;
    end
  endtask : per

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rd(CLK_CFG_OFS, d, r);
    chk("cfg reset", CLK_CFG_RST, d);
    rd(PWM_CTRL_OFS, d, r);
    chk("ctrl reset", PWM_CTRL_RST, d);
    rd(PWM_DUTY_OFS, d, r);
    chk("duty reset", PWM_DUTY_RST, d);
    rd(8'h10, d, r);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(CLK_STATUS_OFS, 32'hFFFF_FFFF, r);
    chk("status write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    rd(CLK_STATUS_OFS, d, r);
    chk("secondary active", 32'h1, {31'h0, d[STS_SEC_BIT]});
    $display("test regs done");
  endtask : t_regs

  task automatic t_clk();
    int          n;
    logic [31:0] d;
    logic [1:0]  r;
    int          ex [4] = '{16, 24, 32, 64};
    for (int s = 0; s < 4; s++) begin
      wr(CLK_CFG_OFS, 32'h0001_0101 | (32'(s) << PIX_SEL_LSB), r);
      repeat (300) @(posedge sys_clk);
      per(2, n);
      chk("pixel period", ex[s], n);
    end
    per(0, n);
    chk("bus period", 16, n);
    per(1, n);
    chk("memory period", 32, n);
    rd(CLK_CFG_OFS, d, r);
    chk("cfg readback", 32'h0301_0101, d);
    $display("test clocks done");
  endtask : t_clk

  task automatic t_pwm();
    logic [1:0]  r;
    logic [31:0] ctl [8] = '{32'h0005_0000, 32'h0005_0101, 32'h0005_0200, 32'h0005_0300,
                             32'h0007_0000, 32'h0001_0000, 32'h0004_0000, 32'h0002_0000};
    int          dty [8] = '{64, 128, 255, 0, 64, 64, 64, 64};
    int          win [8] = '{2048, 6144, 8192, 2048, 2048, 2048, 2048, 2048};
    int          hi  [8] = '{512, 3072, 8160, 0, 2048, 0, 0, 2048};
    for (int i = 0; i < 8; i++) begin
      wr(PWM_DUTY_OFS, 32'(dty[i]), r);
      wr(PWM_CTRL_OFS, ctl[i], r);
      repeat (win[i] + 1100) @(posedge sys_clk);
      clr <= 1'b1;
      @(posedge sys_clk);
      clr <= 1'b0;
      repeat (win[i]) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("pwm high time", hi[i], {16'h0, highCnt});
    end
    wr(CLK_CFG_OFS, 32'h0301_0001, r);
    chk("unity memory resp", {30'h0, RESP_OKAY}, {30'h0, r});
    $display("test pwm done");
  endtask : t_pwm

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    {srst, clr, awValid, wValid, bReady, arValid, rReady} = 7'h40;
    awAddr       = 8'h00;
    arAddr       = 8'h00;
    wData        = 32'h0000_0000;
    err_total    = 0;
    total_checks = 0;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    t_regs();
    t_clk();
    t_pwm();
    end_sim();
  end
endmodule : tb_top

bind ctpg_clock_tree ctpg_clock_tree_chk uChk (.sys_clk(sys_clk), .srst(srst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .busClock(busClock));

`default_nettype wire
